// ===== flyback_pkg.sv
package flyback_pkg;

  // Clock
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Oscillator options and limits
  localparam int unsigned FREQ_LOW_KHZ  = 65;
  localparam int unsigned FREQ_HIGH_KHZ = 100;
  localparam int unsigned FOLD_MIN_KHZ  = 27;
  localparam int unsigned MAX_DUTY_PCT  = 80;
  localparam int unsigned JITTER_PCT    = 6;
  localparam int unsigned JITTER_HZ     = 125;
  localparam int unsigned JITTER_CYC    = CLK_HZ / JITTER_HZ;

  // Blanking after turn-on, least time so rounded up
  localparam int unsigned BLANK_NS  = 250;
  localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Soft-start
  localparam int unsigned SS_STEPS   = 15;
  localparam int unsigned SS_TIME_US = 4000;
  localparam int unsigned SS_CYC     = SS_TIME_US * (CLK_HZ / 1_000_000);

  // Fault and restart timing
  localparam int unsigned FAULT_TIME_MS   = 128;
  localparam int unsigned FAULT_CYC       = FAULT_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned AUTOREC_TIME_MS = 1000;
  localparam int unsigned AUTOREC_CYC     = AUTOREC_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned LINE_WDOG_MS    = 32;
  localparam int unsigned LINE_WDOG_CYC   = LINE_WDOG_MS * (CLK_HZ / 1000);

  // Internal setpoint slope magnitude, applied as a negative slope
  localparam int unsigned SLOPE_LOW_UV_PER_US  = 32_500;
  localparam int unsigned SLOPE_HIGH_UV_PER_US = 50_000;

  // Widths
  localparam int unsigned PER_W      = 16;
  localparam int unsigned SS_CODE_W  = 4;
  localparam int unsigned FOLD_W     = 4;
  localparam int unsigned LINE_W     = 3;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned TIMER_W    = 32;

  // Register map
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LINE   = 8'h08;
  localparam logic [1:0]        CTRL_RESET = 2'h3;
  localparam int unsigned CTRL_JITTER_BIT  = 0;
  localparam int unsigned CTRL_FOLD_BIT    = 1;
  localparam int unsigned STAT_STATE_LSB   = 0;
  localparam int unsigned STAT_GATE_BIT    = 4;
  localparam int unsigned STAT_SKIP_BIT    = 5;
  localparam int unsigned STAT_FTIMER_BIT  = 6;
  localparam int unsigned STAT_COMP_BIT    = 7;
  localparam int unsigned STAT_SS_LSB      = 8;
  localparam int unsigned STAT_MAXDUTY_BIT = 12;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_SOFT    = 3'b001,
    ST_RUN     = 3'b010,
    ST_SKIP    = 3'b011,
    ST_RECOVER = 3'b100,
    ST_LATCH   = 3'b101
  } ctrl_state_t;

  // Switching period in clock cycles for a frequency in kHz
  function automatic int unsigned period_cyc(input int unsigned khz);
    return CLK_HZ / (khz * 1000);
  endfunction : period_cyc

  // Longest on time within one period
  function automatic logic [PER_W-1:0] duty_limit(input logic [PER_W-1:0] per);
    logic [PER_W+7:0] prod;
    prod = per * 8'(MAX_DUTY_PCT);
    return PER_W'(prod / 100);
  endfunction : duty_limit

endpackage : flyback_pkg

// ===== flag_sync.sv
module flag_sync
  import flyback_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // Two stages; only the second is read downstream
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : flag_sync

// ===== pwm_oscillator.sv
module pwm_oscillator
  import flyback_pkg::*;
#(
  parameter int unsigned NOM_PERIOD   = 1923,
  parameter int unsigned MIN_PERIOD   = 4629,
  parameter int unsigned JIT_DEV      = 115,
  parameter int unsigned JIT_STEP_CYC = 2173
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              jitter_en,
  input  wire logic [FOLD_W-1:0] fold_code,
  output logic                   cycle_start,
  output logic                   duty_max
);

  localparam int FOLD_SPAN = int'(MIN_PERIOD) - int'(NOM_PERIOD);
  localparam int FOLD_MAX  = (1 << FOLD_W) - 1;

  logic [PER_W-1:0] phase_reg;
  logic [PER_W-1:0] period_reg;
  logic [PER_W-1:0] limit_reg;
  logic [PER_W-1:0] period_next;
  logic [PER_W-1:0] jit_reg;
  logic             jit_up_reg;
  logic [31:0]      jit_div_reg;
  logic             jit_step;
  int               target;

  // Foldback stretches the period linearly; jitter rides on top of it
  always_comb begin
    target = int'(NOM_PERIOD) + (FOLD_SPAN * int'(fold_code)) / FOLD_MAX;
    if (jitter_en) begin
      target = target + int'($signed(jit_reg));
    end
    period_next = PER_W'(target);
  end

  assign cycle_start = (phase_reg == '0);
  assign duty_max    = (phase_reg >= limit_reg);
  assign jit_step    = (jit_div_reg == JIT_STEP_CYC - 1);

  // Period counter; new period and duty limit load only at the wrap
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_reg  <= '0;
      period_reg <= PER_W'(NOM_PERIOD);
      limit_reg  <= PER_W'(NOM_PERIOD * MAX_DUTY_PCT / 100);
    end else if (phase_reg >= period_reg - 1'b1) begin
      phase_reg  <= '0;
      period_reg <= period_next;
      limit_reg  <= duty_limit(period_next);
    end else begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  // Triangle offset, one full sweep per jitter period
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      jit_reg     <= '0;
      jit_up_reg  <= 1'b1;
      jit_div_reg <= '0;
    end else begin
      jit_div_reg <= jit_step ? '0 : jit_div_reg + 1'b1;
      if (jit_step) begin
        if (jit_up_reg && $signed(jit_reg) >= $signed(PER_W'(JIT_DEV))) begin
          jit_up_reg <= 1'b0;
          jit_reg    <= jit_reg - 1'b1;
        end else if (!jit_up_reg && $signed(jit_reg) <= -$signed(PER_W'(JIT_DEV))) begin
          jit_up_reg <= 1'b1;
          jit_reg    <= jit_reg + 1'b1;
        end else begin
          jit_reg <= jit_up_reg ? jit_reg + 1'b1 : jit_reg - 1'b1;
        end
      end
    end
  end

endmodule : pwm_oscillator

// ===== flyback_pwm_control_logic.sv
// Notes on behaviour
// - Nominal switching frequency is a build option, 65 kHz or 100 kHz.
// - Gate is forced low once on time reaches 80% of the period.
// - Frequency jitters around nominal with a 125 Hz triangle.
// - Jitter keeps running while the frequency is folded back.
// - On time ends at feedback trip; trips ignored for 250 ns after turn-on.
// - Separate limit comparator ends the on time at the maximum setpoint.
// - Every start ramps the setpoint from zero to maximum in 15 steps.
// - During soft-start either soft-start or feedback comparator ends on time.
// - Stop comparator at 1.5x limit enters protection immediately.
// - Line compensation current on only while feedback is above its threshold.
// - 3-bit line code is sampled, then peak reset, on each line event.
// - A 32 ms watchdog makes the sampling event when none arrives.
// - Negative setpoint slope during on time, rate set by frequency option.
// - Fault timer runs at setpoint limit; expiry stops gate, latch or recover.
// - Fault timer clears when the setpoint falls back below the limit.
// - Fault timer is not started by a cycle ended at maximum duty.
// - Auto-recovery waits the restart delay, then retries a full start.
// - Latched variant stays stopped until undervoltage reset; the code ignores supply stop in ST_LATCH, and only resetn clears it.
// - Below foldback start the period stretches linearly to the folded minimum.
// - Foldback suppressed while cycles run at maximum duty.
// - Skip entry stops the gate and holds while below skip exit.
// - Above skip exit the gate resumes pulsing at the next cycle start.
// - Supply at stop threshold turns off and clears the fault timer.
module flyback_pwm_control_logic
  import flyback_pkg::*;
#(
  parameter bit          FREQ_HIGH      = 1'b0,
  parameter bit          AUTO_RECOVERY  = 1'b1,
  parameter int unsigned SOFT_CYC       = SS_CYC,
  parameter int unsigned FAULT_LEN_CYC  = FAULT_CYC,
  parameter int unsigned RESTART_CYC    = AUTOREC_CYC,
  parameter int unsigned WDOG_CYC       = LINE_WDOG_CYC,
  parameter int unsigned JIT_SWEEP_CYC  = JITTER_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              supply_start_flag,
  input  wire logic              supply_stop_flag,
  input  wire logic              cs_fb_trip,
  input  wire logic              cs_limit_trip,
  input  wire logic              cs_soft_trip,
  input  wire logic              cs_stop_trip,
  input  wire logic              setpoint_at_limit,
  input  wire logic              fb_comp_enable_flag,
  input  wire logic              fb_skip_in_flag,
  input  wire logic              fb_skip_out_flag,
  input  wire logic              line_sample_flag,
  input  wire logic [FOLD_W-1:0] fold_code,
  input  wire logic [LINE_W-1:0] line_adc_code,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   gate_drive_output,
  output logic   [SS_CODE_W-1:0] soft_start_code,
  output logic                   slope_comp_active,
  output logic      [31:0]       slope_uv_per_us,
  output logic                   comp_current_enable,
  output logic                   line_peak_reset,
  output logic      [LINE_W-1:0] line_code,
  output logic                   skip_active,
  output logic                   fault_stop
);

  // Build-time frequency choice
  localparam int unsigned NOM_KHZ    = FREQ_HIGH ? FREQ_HIGH_KHZ : FREQ_LOW_KHZ;
  localparam int unsigned NOM_PER    = period_cyc(NOM_KHZ);
  localparam int unsigned MIN_PER    = period_cyc(FOLD_MIN_KHZ);
  localparam int unsigned JIT_DEVN   = NOM_PER * JITTER_PCT / 100;
  localparam int unsigned JIT_STEP   = JIT_SWEEP_CYC / (4 * JIT_DEVN);
  localparam int unsigned SS_STEP_CYC = SOFT_CYC / SS_STEPS;

  // Synchroniser lane positions
  localparam int unsigned F_SUP_ON  = 0;
  localparam int unsigned F_SUP_OFF = 1;
  localparam int unsigned F_CS_FB   = 2;
  localparam int unsigned F_CS_LIM  = 3;
  localparam int unsigned F_CS_SS   = 4;
  localparam int unsigned F_CS_STOP = 5;
  localparam int unsigned F_AT_LIM  = 6;
  localparam int unsigned F_COMP    = 7;
  localparam int unsigned F_SKIP_IN = 8;
  localparam int unsigned F_SKIP_OUT = 9;
  localparam int unsigned F_LINE    = 10;
  localparam int unsigned NFLAGS    = 11;

  logic [NFLAGS-1:0]    flags_raw;
  logic [NFLAGS-1:0]    flags;
  ctrl_state_t          state_reg;
  ctrl_state_t          state_next;
  logic                 gate_reg;
  logic                 gate_next;
  logic [7:0]           blank_reg;
  logic                 blank_done;
  logic                 maxduty_end_reg;
  logic                 cycle_start;
  logic                 duty_max;
  logic                 switching;
  logic                 cs_trip;
  logic                 turn_off;
  logic [SS_CODE_W-1:0] ss_code_reg;
  logic [TIMER_W-1:0]   ss_div_reg;
  logic                 ss_step;
  logic                 ss_done;
  logic [TIMER_W-1:0]   fault_cnt_reg;
  logic                 fault_count_en;
  logic                 fault_expired;
  logic                 protect;
  logic [TIMER_W-1:0]   restart_cnt_reg;
  logic                 restart_done;
  logic [TIMER_W-1:0]   wdog_reg;
  logic                 line_prev_reg;
  logic                 line_event;
  logic                 peak_reset_reg;
  logic [LINE_W-1:0]    line_code_reg;
  logic [1:0]           ctrl_reg;
  logic [FOLD_W-1:0]    fold_eff;
  logic [DATA_W-1:0]    status_word;
  logic [DATA_W-1:0]    rd_mux;
  logic                 comp_reg;

  assign flags_raw = {line_sample_flag, fb_skip_out_flag, fb_skip_in_flag,
                      fb_comp_enable_flag, setpoint_at_limit, cs_stop_trip,
                      cs_soft_trip, cs_limit_trip, cs_fb_trip,
                      supply_stop_flag, supply_start_flag};

  // Comparator crossings come from the analogue side
  flag_sync #(
    .W (NFLAGS)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in (flags_raw),
    .sync_out (flags)
  );

  // No foldback at max duty, or when software turns it off
  assign fold_eff = (maxduty_end_reg || !ctrl_reg[CTRL_FOLD_BIT]) ? '0 : fold_code;

  // Jitter stays live on the folded period too
  pwm_oscillator #(
    .NOM_PERIOD   (NOM_PER),
    .MIN_PERIOD   (MIN_PER),
    .JIT_DEV      (JIT_DEVN),
    .JIT_STEP_CYC (JIT_STEP)
  ) u_osc (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .jitter_en   (ctrl_reg[CTRL_JITTER_BIT]),
    .fold_code   (fold_eff),
    .cycle_start (cycle_start),
    .duty_max    (duty_max)
  );

  // Gate turn-off decode
  assign switching  = (state_reg == ST_SOFT) || (state_reg == ST_RUN);
  assign blank_done = (blank_reg >= 8'(BLANK_CYC));
  assign cs_trip    = flags[F_CS_FB] || flags[F_CS_LIM]
                      || ((state_reg == ST_SOFT) && flags[F_CS_SS]);
  assign turn_off   = gate_reg && (duty_max || (blank_done && cs_trip));

  always_comb begin
    gate_next = gate_reg;
    if (!switching || protect || state_next == ST_SKIP) begin
      gate_next = 1'b0;
    end else if (cycle_start) begin
      gate_next = 1'b1;
    end else if (turn_off) begin
      gate_next = 1'b0;
    end
  end

  // Gate, blanking counter and the cause of each comparator or max-duty turn-off
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_reg        <= 1'b0;
      blank_reg       <= '0;
      maxduty_end_reg <= 1'b0;
    end else begin
      gate_reg <= gate_next;
      if (cycle_start) begin
        blank_reg <= '0;
      end else if (gate_reg && !blank_done) begin
        blank_reg <= blank_reg + 1'b1;
      end
      if (turn_off) begin
        maxduty_end_reg <= duty_max && !(blank_done && cs_trip);
      end
    end
  end

  // Soft-start staircase, one step per SS_STEP_CYC
  assign ss_step = (ss_div_reg == TIMER_W'(SS_STEP_CYC - 1));
  assign ss_done = (ss_code_reg == SS_CODE_W'(SS_STEPS));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ss_code_reg <= '0;
      ss_div_reg  <= '0;
    end else if (state_reg != ST_SOFT) begin
      ss_code_reg <= (state_reg == ST_OFF || state_reg == ST_RECOVER) ? '0 : ss_code_reg;
      ss_div_reg  <= '0;
    end else if (!ss_done) begin
      ss_div_reg <= ss_step ? '0 : ss_div_reg + 1'b1;
      if (ss_step) begin
        ss_code_reg <= ss_code_reg + 1'b1;
      end
    end
  end

  // Fault timer: needs the limit, and a start not caused by max duty
  assign fault_count_en = flags[F_AT_LIM] && switching
                          && ((fault_cnt_reg != '0) || !maxduty_end_reg);
  assign fault_expired  = (fault_cnt_reg == TIMER_W'(FAULT_LEN_CYC - 1));
  assign protect        = switching && (flags[F_CS_STOP] || fault_expired);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_cnt_reg <= '0;
    end else if (state_reg == ST_OFF || !flags[F_AT_LIM] || protect) begin
      fault_cnt_reg <= '0;
    end else if (fault_count_en) begin
      fault_cnt_reg <= fault_cnt_reg + 1'b1;
    end
  end

  // Restart delay for the auto-recovery variant
  assign restart_done = (restart_cnt_reg == TIMER_W'(RESTART_CYC - 1));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      restart_cnt_reg <= '0;
    end else if (state_reg == ST_RECOVER) begin
      restart_cnt_reg <= restart_cnt_reg + 1'b1;
    end else begin
      restart_cnt_reg <= '0;
    end
  end

  // Controller sequence; protection outranks skip and soft-start
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (flags[F_SUP_ON] && !flags[F_SUP_OFF]) begin
          state_next = ST_SOFT;
        end
      end
      ST_SOFT, ST_RUN, ST_SKIP: begin
        if (flags[F_SUP_OFF]) begin
          state_next = ST_OFF;
        end else if (protect) begin
          state_next = AUTO_RECOVERY ? ST_RECOVER : ST_LATCH;
        end else if (state_reg == ST_SOFT) begin
          if (ss_done) begin
            state_next = ST_RUN;
          end
        end else if (state_reg == ST_RUN) begin
          if (flags[F_SKIP_IN]) begin
            state_next = ST_SKIP;
          end
        end else if (flags[F_SKIP_OUT]) begin
          state_next = ST_RUN;
        end
      end
      ST_RECOVER: begin
        if (flags[F_SUP_OFF]) begin
          state_next = ST_OFF;
        end else if (restart_done) begin
          state_next = ST_SOFT;
        end
      end
      ST_LATCH: begin
        state_next = ST_LATCH;
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Line sampling: comparator edge or watchdog, whichever first
  assign line_event = (flags[F_LINE] && !line_prev_reg)
                      || (wdog_reg == TIMER_W'(WDOG_CYC - 1));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      line_prev_reg  <= 1'b0;
      wdog_reg       <= '0;
      peak_reset_reg <= 1'b0;
      line_code_reg  <= '0;
    end else begin
      line_prev_reg  <= flags[F_LINE];
      wdog_reg       <= line_event ? '0 : wdog_reg + 1'b1;
      peak_reset_reg <= line_event;
      if (line_event) begin
        line_code_reg <= line_adc_code;
      end
    end
  end

  // Compensation current only above its feedback threshold
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      comp_reg <= 1'b0;
    end else begin
      comp_reg <= flags[F_COMP] && (state_next == ST_RUN || state_next == ST_SOFT);
    end
  end

  // Software registers; writes to read-only offsets are dropped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg  <= CTRL_RESET;
      reg_rdata <= '0;
    end else begin
      if (reg_write && reg_addr == REG_CTRL) begin
        ctrl_reg <= reg_wdata[1:0];
      end
      reg_rdata <= reg_read ? rd_mux : '0;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[STAT_STATE_LSB +: 3]         = state_reg;
    status_word[STAT_GATE_BIT]               = gate_reg;
    status_word[STAT_SKIP_BIT]               = (state_reg == ST_SKIP);
    status_word[STAT_FTIMER_BIT]             = (fault_cnt_reg != '0);
    status_word[STAT_COMP_BIT]               = comp_reg;
    status_word[STAT_SS_LSB +: SS_CODE_W]    = ss_code_reg;
    status_word[STAT_MAXDUTY_BIT]            = maxduty_end_reg;
  end

  assign rd_mux = (reg_addr == REG_CTRL)   ? {30'h0000_0000, ctrl_reg} :
                  (reg_addr == REG_STATUS) ? status_word :
                  (reg_addr == REG_LINE)   ? {29'h0000_0000, line_code_reg} :
                                             32'h0000_0000;

  // Outputs; the slope rate follows the frequency option
  assign gate_drive_output   = gate_reg;
  assign soft_start_code     = ss_code_reg;
  assign slope_comp_active   = gate_reg;
  assign slope_uv_per_us     = FREQ_HIGH ? SLOPE_HIGH_UV_PER_US
                                         : SLOPE_LOW_UV_PER_US;
  assign comp_current_enable = comp_reg;
  assign line_peak_reset     = peak_reset_reg;
  assign line_code           = line_code_reg;
  assign skip_active         = (state_reg == ST_SKIP);
  assign fault_stop          = (state_reg == ST_RECOVER) || (state_reg == ST_LATCH);

endmodule : flyback_pwm_control_logic

// ===== flyback_chk.sv
module flyback_chk
  import flyback_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  input wire logic                 gate_drive_output,
  input wire logic                 slope_comp_active,
  input wire logic                 skip_active,
  input wire logic                 fault_stop,
  input wire logic                 cs_stop_trip,
  input wire logic                 fb_skip_out_flag,
  input wire logic                 fb_comp_enable_flag,
  input wire logic                 comp_current_enable,
  input wire logic                 line_peak_reset,
  input wire logic [SS_CODE_W-1:0] soft_start_code
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Jitter can stretch the period by 6%, so the duty bound uses the longest period
  localparam int ON_MAX = 1630;
  int on_cnt;
  // Gate-high run length
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      on_cnt <= 0;
    else
      on_cnt <= gate_drive_output ? on_cnt + 1 : 0;
  end
  sequence s_stop; $rose(cs_stop_trip) && gate_drive_output; endsequence
  sequence s_exit; $rose(fb_skip_out_flag) && skip_active; endsequence
  property p_stop; s_stop |-> ##[1:4] fault_stop; endproperty
  property p_exit; s_exit |-> ##[1:4] !skip_active; endproperty
  property p_blank;
    $fell(gate_drive_output) && !fault_stop && !skip_active |-> on_cnt >= BLANK_CYC;
  endproperty
  property p_duty; gate_drive_output |-> on_cnt < ON_MAX; endproperty
  property p_quiet; skip_active || fault_stop |-> !gate_drive_output; endproperty
  property p_slope; slope_comp_active == gate_drive_output; endproperty
  property p_comp;
    (fb_comp_enable_flag[*4] |-> comp_current_enable)
    and (!fb_comp_enable_flag[*4] |-> !comp_current_enable);
  endproperty
  property p_peak; line_peak_reset |=> !line_peak_reset; endproperty
  property p_ss;
    $changed(soft_start_code) && soft_start_code != 0
      |-> soft_start_code == 4'($past(soft_start_code) + 1);
  endproperty
  a_stop: assert property (p_stop) else $error("no protection");
  a_exit: assert property (p_exit) else $error("skip held");
  a_blank: assert property (p_blank) else $error("blank");
  a_duty: assert property (p_duty) else $error("duty");
  a_quiet: assert property (p_quiet) else $error("gate on");
  a_slope: assert property (p_slope) else $error("slope");
  a_comp: assert property (p_comp) else $error("comp");
  a_peak: assert property (p_peak) else $error("peak");
  a_ss: assert property (p_ss) else $error("soft step");
endmodule : flyback_chk

bind flyback_pwm_control_logic flyback_chk i_chk (.clk_sys, .resetn, .gate_drive_output,
  .slope_comp_active, .skip_active, .fault_stop, .cs_stop_trip, .fb_skip_out_flag,
  .fb_comp_enable_flag, .comp_current_enable, .line_peak_reset, .soft_start_code);

// ===== cs_model.sv
module cs_model (
  input wire logic clk_sys,
  input wire logic gate_drive_output,
  input wire logic stop_en,
  input int        fb_at,
  input int        lim_at,
  input int        soft_at,
  output logic     cs_fb_trip,
  output logic     cs_limit_trip,
  output logic     cs_soft_trip,
  output logic     cs_stop_trip
);
  timeunit 1ns / 1ps;
  int cnt;
  // Sense ramp grows only while the switch conducts, drops to zero at turn-off
  always @(posedge clk_sys) cnt <= gate_drive_output ? cnt + 1 : 0;
  // Trips hold while the ramp stays above each level
  assign cs_fb_trip    = gate_drive_output && cnt >= fb_at;
  assign cs_limit_trip = gate_drive_output && cnt >= lim_at;
  assign cs_soft_trip  = gate_drive_output && cnt >= soft_at;
  assign cs_stop_trip  = gate_drive_output && stop_en;
endmodule : cs_model

// ===== tb_top.sv
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WT(c, m) begin k = 0; #1; while (!(c) && k < (m)) begin @(posedge clk_sys); #1; k++; end \
  if (!(c)) begin n_fail++; test_done(); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flyback_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, supply_start_flag = 1'b0, supply_stop_flag = 1'b0;
  logic setpoint_at_limit = 1'b0, fb_comp_enable_flag = 1'b0, fb_skip_in_flag = 1'b0;
  logic fb_skip_out_flag = 1'b0, line_sample_flag = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic stop_en = 1'b0, cs_fb_trip, cs_limit_trip, cs_soft_trip, cs_stop_trip;
  logic gate_drive_output, slope_comp_active, comp_current_enable, line_peak_reset;
  logic skip_active, fault_stop;
  logic [FOLD_W-1:0]    fold_code = 4'h0;
  logic [LINE_W-1:0]    line_adc_code = 3'h0, line_code;
  logic [ADDR_W-1:0]    reg_addr = 8'h00;
  logic [DATA_W-1:0]    reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic [SS_CODE_W-1:0] soft_start_code;
  logic [31:0]          slope_uv_per_us;
  int fb_at = 100, lim_at = 5000, soft_at = 5000, n, k, n_fail = 0, n_compared = 0;
  // Short counts keep the run small
  flyback_pwm_control_logic #(.SOFT_CYC(150), .FAULT_LEN_CYC(200), .RESTART_CYC(100),
    .WDOG_CYC(300), .JIT_SWEEP_CYC(10000)) i_flyback_pwm_control_logic (.clk_sys, .resetn,
    .supply_start_flag, .supply_stop_flag, .cs_fb_trip, .cs_limit_trip, .cs_soft_trip,
    .cs_stop_trip, .setpoint_at_limit, .fb_comp_enable_flag, .fb_skip_in_flag,
    .fb_skip_out_flag, .line_sample_flag, .fold_code, .line_adc_code, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .gate_drive_output, .soft_start_code,
    .slope_comp_active, .slope_uv_per_us, .comp_current_enable, .line_peak_reset,
    .line_code, .skip_active, .fault_stop);
  cs_model i_cs_model (.clk_sys, .gate_drive_output, .stop_en, .fb_at, .lim_at, .soft_at,
    .cs_fb_trip, .cs_limit_trip, .cs_soft_trip, .cs_stop_trip);
  initial forever #4 clk_sys = ~clk_sys;
  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task wr(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= 32'hFFFF_FFFF;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  // Length of one whole gate pulse, skipping any pulse already under way
  task on_time;
    `WT(!gate_drive_output, 3000)
    `WT(gate_drive_output, 3000)
    n = 0;
    while (gate_drive_output && n < 3000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : on_time
  task t_start;
    @(posedge clk_sys) supply_start_flag <= 1'b1;
    fb_at = 10;
    on_time();
    `CHK(n >= 31 && n <= 40, 1'b1)
    fb_at = 100;
    `WT(soft_start_code == 4'hF, 5000)
    rd(REG_STATUS);
    `CHK(d[2:0], 3'h2)
  endtask : t_start
  task t_limit;
    fb_at = 5000;
    lim_at = 60;
    on_time();
    `CHK(n >= 59 && n <= 68, 1'b1)
    lim_at = 5000;
    on_time();
    `CHK(n >= 1400 && n <= 1630, 1'b1)
    rd(REG_STATUS);
    `CHK(d[STAT_MAXDUTY_BIT], 1'b1)
    fb_at = 100;
  endtask : t_limit
  task t_fault;
    @(posedge clk_sys) setpoint_at_limit <= 1'b1;
    `WT(fault_stop, 3000)
    `CHK(gate_drive_output, 1'b0)
    @(posedge clk_sys) setpoint_at_limit <= 1'b0;
    `WT(!fault_stop, 200)
    rd(REG_STATUS);
    `CHK(d[2:0], 3'h1)
    @(posedge clk_sys) stop_en <= 1'b1;
    `WT(fault_stop, 3000)
    `CHK(gate_drive_output, 1'b0)
    @(posedge clk_sys) stop_en <= 1'b0;
    `WT(soft_start_code == 4'hF, 5000)
  endtask : t_fault
  task t_skip;
    @(posedge clk_sys) fb_skip_in_flag <= 1'b1;
    `WT(skip_active, 3000)
    `CHK(gate_drive_output, 1'b0)
    @(posedge clk_sys) fb_skip_in_flag <= 1'b0;
    fb_skip_out_flag <= 1'b1;
    `WT(gate_drive_output, 3000)
    `CHK(skip_active, 1'b0)
  endtask : t_skip
  task t_line;
    @(posedge clk_sys) line_adc_code <= 3'h5;
    line_sample_flag <= 1'b1;
    fb_comp_enable_flag <= 1'b1;
    `WT(line_peak_reset, 20)
    `CHK(line_code, 3'h5)
    `CHK(comp_current_enable, 1'b1)
    @(posedge clk_sys) line_sample_flag <= 1'b0;
    line_adc_code <= 3'h3;
    #1;
    `WT(line_peak_reset, 400)
    rd(REG_LINE);
    `CHK(d[2:0], 3'h3)
  endtask : t_line
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(REG_CTRL);
    `CHK(d[1:0], CTRL_RESET)
    wr(8'hFC);
    rd(8'hFC);
    `CHK(d, 32'h0000_0000)
    `CHK(slope_uv_per_us, 32'(SLOPE_LOW_UV_PER_US))
    t_start();
    t_limit();
    t_fault();
    t_skip();
    t_line();
    @(posedge clk_sys) {supply_stop_flag, fb_comp_enable_flag} <= 2'h2;
    rd(REG_STATUS);
    rd(REG_STATUS);
    `CHK(d[2:0], 3'h0)
    test_done();
  end
endmodule : tb_top
